// [design/urx_pkg.sv]
// Purpose: shared types and constants for the receive recovery front end
// Assumes: one system clock; oversampling tick made elsewhere from the baud divisor
// Notes:   counts are sample numbers within one bit, starting at one
package urx_pkg;

    // ------------------------------------------------------------
    // timing of the oversampled bit
    // ------------------------------------------------------------
    localparam int          CNT_W            = 5;
    localparam logic [4:0]  SAMPLES_NORMAL   = 5'h10;  // 16 samples per bit
    localparam logic [4:0]  SAMPLES_DOUBLE   = 5'h08;  // 8 samples per bit
    localparam logic [4:0]  CENTRE_NORMAL    = 5'h08;  // first centre sample
    localparam logic [4:0]  CENTRE_DOUBLE    = 5'h04;
    localparam logic [4:0]  CENTRE_SPAN      = 5'h02;  // last centre = first + 2
    localparam logic [4:0]  FIRST_SAMPLE     = 5'h01;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int          DATA_W           = 10;     // data plus parity, at most
    localparam logic [3:0]  FRAME_BITS_MIN   = 4'h5;
    localparam logic [3:0]  FRAME_BITS_MAX   = 4'ha;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        LINE_IDLE        = 1'b1;

    typedef enum logic [1:0] {
        URX_IDLE  = 2'b00,
        URX_START = 2'b01,
        URX_BITS  = 2'b11
    } urx_state_t;

    // one received frame as it sits in the buffer
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              frame_error_flag;
    } urx_word_t;

    // whole state of the receiver
    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              prev;
        urx_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic [3:0]        bit_idx;
        logic [2:0]        votes;
        logic [DATA_W-1:0] shreg;
        urx_word_t         slot0;
        urx_word_t         slot1;
        logic              wr_ptr;
        logic              rd_ptr;
        logic [1:0]        fill;
        logic              overrun;
    } urx_regs_t;

endpackage : urx_pkg

// [design/urx_recovery.sv]
// Purpose: clock and data recovery for the asynchronous receive line
// Assumes: sample_tick is a one-cycle pulse at 16x (8x in double speed) the baud rate
// Notes:   frames leave through a two-entry buffer; a full buffer not popped in that cycle drops the frame
//          the line cannot be stalled, so dropping the newest frame keeps the
//          oldest words intact and reports the loss on overrun instead
//          double_speed_select and frame_bits must not change inside a frame
//          frame_bits outside 5..10 is clamped rather than refused
//          there is no rate correction inside a frame: each start bit re-aligns
//          the counter, and the far end has to stay within its share of the error
//          sample_tick must leave at least one idle cycle between pulses
//          only the first stop bit is looked at; longer stops are plain idle time
`timescale 1ns/1ps

module urx_recovery (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // configuration and timing
    input  wire logic                     sample_tick,
    input  wire logic                     double_speed_select,
    input  wire logic [3:0]               frame_bits,
    // serial line
    input  wire logic                     rx_line,
    // received frames
    output      logic                     out_valid,
    input  wire logic                     out_ready,
    output      urx_pkg::urx_word_t       out_word,
    output      logic                     overrun
);
    import urx_pkg::*;

    urx_regs_t r;
    urx_regs_t next_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // majority of three: the low pass filter applied to every bit
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    // clamp the frame length so a bad setting cannot overrun the shift register
    function automatic logic [3:0] clamp_bits(input logic [3:0] n);
        if (n < FRAME_BITS_MIN) begin
            clamp_bits = FRAME_BITS_MIN;
        end else if (n > FRAME_BITS_MAX) begin
            clamp_bits = FRAME_BITS_MAX;
        end else begin
            clamp_bits = n;
        end
    endfunction : clamp_bits

    logic [4:0] samples_per_bit;
    logic [4:0] centre_first;
    logic [4:0] centre_last;
    logic [3:0] stop_idx;
    logic       line;

    // mode-dependent sample numbers
    // oversampling rate
    assign samples_per_bit = double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    assign centre_first    = double_speed_select ? CENTRE_DOUBLE : CENTRE_NORMAL;
    assign centre_last     = centre_first + CENTRE_SPAN;
    // bit 0 is the start bit, so the first stop bit sits one past the data
    assign stop_idx        = clamp_bits(frame_bits) + 4'h1;
    // only the second sync flop is read, so a metastable first flop never reaches logic
    assign line            = r.sync2;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic      bit_val;
        logic      push;
        logic      pop;
        urx_word_t fresh;
        bit_val = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        fresh   = '0;
        next_r  = r;

        next_r.sync1   = rx_line;
        next_r.sync2   = r.sync1;
        next_r.overrun = 1'b0;

        // sample numbering: r.cnt holds the number of the sample taken on the
        // previous tick, so the current tick takes sample r.cnt + 1, and the
        // tick that finds r.cnt at the last state is sample one of the next bit
        // votes[1:0] hold the two samples before this one, so at the last centre
        // sample the vote sees exactly the three centre samples of the bit
        if (sample_tick) begin
            next_r.prev = line;
            // shift every sample in; only the centre three are ever voted on
            next_r.votes = {r.votes[1:0], line};
            bit_val      = maj3({r.votes[1:0], line});
            case (r.st)
                URX_IDLE: begin
                    // prev holds the last sample taken, which after a frame is the
                    // stop bit's last centre sample, so an early start is caught
                    // falling edge on idle line
                    if (r.prev && !line) begin
                        next_r.st      = URX_START;
                        next_r.cnt     = FIRST_SAMPLE;
                        next_r.bit_idx = 4'h0;
                    end
                end
                URX_START, URX_BITS: begin
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == samples_per_bit) begin
                        next_r.cnt     = FIRST_SAMPLE;
                        next_r.bit_idx = r.bit_idx + 4'h1;
                        next_r.st      = URX_BITS;
                    end
                    if (r.cnt + 5'h01 == centre_last) begin
                        if (r.bit_idx == 4'h0) begin
                            if (bit_val) begin
                                next_r.st  = URX_IDLE;
                                next_r.cnt = '0;
                            end
                            // timing stays locked to this start bit
                            // from here on every bit is counted from this sample one
                        end else if (r.bit_idx == stop_idx) begin
                            // only the first stop bit is used
                            fresh.data             = r.shreg;
                            fresh.frame_error_flag = ~bit_val;
                            push                   = 1'b1;
                            // back to edge search at once
                            next_r.st              = URX_IDLE;
                            next_r.cnt             = '0;
                            // cleared so bits above a short frame read zero next time
                            next_r.shreg           = '0;
                        end else begin
                            next_r.shreg[r.bit_idx - 4'h1] = bit_val;
                        end
                    end
                end
                default: begin
                    // unused encoding: fall back to edge search
                    next_r.st  = URX_IDLE;
                    next_r.cnt = '0;
                end
            endcase
        end

        // --------------------------------------------------------
        // output buffer
        // --------------------------------------------------------
        // wr_ptr names the slot the next frame goes to, rd_ptr the head;
        // fill tells full from empty, which equal pointers cannot
        // two-entry buffer; the line cannot be stalled, so a push into a full buffer
        // with no pop in the same cycle is dropped and reported instead of overwriting
        pop = out_ready && (r.fill != 2'h0);
        if (push && (r.fill == 2'h2) && !pop) begin
            push           = 1'b0;
            next_r.overrun = 1'b1;
        end
        if (push) begin
            if (r.wr_ptr) begin
                next_r.slot1 = fresh;
            end else begin
                next_r.slot0 = fresh;
            end
            next_r.wr_ptr = ~r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr = ~r.rd_ptr;
        end
        next_r.fill = r.fill + {1'b0, push} - {1'b0, pop};
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r       <= '0;
            // prev starts high too, else a start edge on the first tick would go unseen
            // idle high after reset
            r.sync1 <= LINE_IDLE;
            r.sync2 <= LINE_IDLE;
            r.prev  <= LINE_IDLE;
            r.st    <= URX_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign out_valid = (r.fill != 2'h0);
    // both slots are flops; the head mux adds no state and keeps out_word
    // steady while out_valid is high and nothing is popped
    assign out_word  = r.rd_ptr ? r.slot1 : r.slot0;
    assign overrun   = r.overrun;

endmodule : urx_recovery

// [bench/urx_props.sv]
// Purpose: port checks for urx_recovery
// Assumes: sample_tick pulses at most every other cycle
// Notes:   quiet counts ticks since the line was last low, saturating
`timescale 1ns/1ps
module urx_props (
    // clock and reset
    input wire logic               sys_clk,
    input wire logic               rst,
    // inputs
    input wire logic               sample_tick,
    input wire logic [3:0]         frame_bits,
    input wire logic               rx_line,
    input wire logic               out_ready,
    // outputs
    input wire logic               out_valid,
    input wire urx_pkg::urx_word_t out_word,
    input wire logic               overrun
);
    import urx_pkg::*;
    logic [7:0] quiet;
    // ----------------------------------------
    // idle line counter
    // ----------------------------------------
    // a frame needs a low start bit, so a long quiet line can finish none
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) quiet <= 8'h00;
        else if (!rx_line) quiet <= 8'h00;
        else if (sample_tick && quiet != 8'hff) quiet <= quiet + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> !out_valid && !overrun)
        else $error("outputs active in reset");
    a_word_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("held word changed");
    a_valid_drop: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("word lost without pop");
    a_push_tick: assert property ($rose(out_valid) |-> $past(sample_tick))
        else $error("frame pushed off a tick");
    a_overrun_cause: assert property (overrun |-> $past(sample_tick) && out_valid)
        else $error("overrun without full buffer");
    a_overrun_pulse: assert property (overrun |=> !overrun)
        else $error("overrun longer than a cycle");
    a_short_frame: assert property (out_valid && frame_bits == 4'h5 |-> out_word.data[9:5] == 5'h00)
        else $error("bits beyond frame length set");
    a_idle_no_frame: assert property ($rose(out_valid) |-> quiet < 8'hc8)
        else $error("frame from an idle line");
    c_overrun: cover property (overrun);
    c_frame_error: cover property (out_valid && out_word.frame_error_flag);
    c_pop_next: cover property (out_valid && out_ready ##1 out_valid);
endmodule : urx_props

bind urx_recovery urx_props CHK (.sys_clk, .rst, .sample_tick, .frame_bits, .rx_line,
    .out_ready, .out_valid, .out_word, .overrun);

// [bench/urx_tx_model.sv]
// Purpose: remote transmitter driving the receive line
// Assumes: called 1 ns after a rising edge
// Notes:   line idles high, as if pulled up
`timescale 1ns/1ps
module urx_tx_model (
    // clock
    input  wire logic sys_clk,
    // serial line
    output      logic rx_line
);
    initial rx_line = 1'b1;
    // exact bit time, no rate error
    task automatic hold(input logic v, input int cyc);
        rx_line = v;
        repeat (cyc) @(posedge sys_clk);
        #1;
    endtask : hold
    // start, data lsb first, one stop of chosen length, back to idle
    task automatic send(input logic [9:0] d, input logic [3:0] n, input logic st,
                        input int bit_cyc, input int stop_cyc);
        hold(1'b0, bit_cyc);
        for (int i = 0; i < n; i++) hold(d[i], bit_cyc);
        hold(st, stop_cyc);
        if (!st) rx_line = 1'b1; // after a high stop the line is already idle
    endtask : send
endmodule : urx_tx_model

// [bench/uart_async_rx_recovery_test.sv]
// Purpose: self-checking bench for urx_recovery
// Assumes: tick every second cycle, so a bit is 32 cycles, 16 in double speed
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module uart_async_rx_recovery_test;
    import urx_pkg::*;
    logic      sys_clk, rst, double_speed_select, out_ready;
    logic      out_valid, overrun, rx_line;
    logic      sample_tick = 1'b0;
    logic      seen_ovr = 1'b0;
    logic [3:0] frame_bits;
    urx_word_t out_word;
    int        err_count, n_compared;
    urx_recovery DUT (.sys_clk, .rst, .sample_tick, .double_speed_select, .frame_bits,
        .rx_line, .out_valid, .out_ready, .out_word, .overrun);
    urx_tx_model TX (.sys_clk, .rx_line);
    // clock, tick pulse every other cycle, overrun catcher
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) #1 sample_tick <= !rst && !sample_tick;
    always @(negedge sys_clk) if (overrun === 1'b1) seen_ovr <= 1'b1; // settled by then
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // a short stop_cyc lets the next start come right after the vote
    task automatic frame(input logic [9:0] d, input logic [3:0] n, input logic st,
                         input logic ds, input int stop_cyc);
        double_speed_select = ds;
        frame_bits = n;
        TX.send(d, n, st, ds ? 16 : 32, stop_cyc);
    endtask : frame
    // bounded wait for a word, compare, pop
    task automatic take(input string what, input logic [10:0] exp);
        int i;
        for (i = 0; i < 40 && out_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk({what, " valid"}, 11'h001, {10'h000, out_valid});
        chk(what, exp, out_word);
        out_ready = 1'b1;
        @(posedge sys_clk);
        #1 out_ready = 1'b0;
        // let an edge pass so a following pop never re-raises out_ready at once
        @(posedge sys_clk);
        #1;
    endtask : take
    task automatic t_formats;
        frame(10'h0a5, 4'h8, 1'b1, 1'b0, 32);
        take("normal 8 bit", {10'h0a5, 1'b0});
        frame(10'h2c3, 4'ha, 1'b1, 1'b1, 16);
        take("double 10 bit", {10'h2c3, 1'b0});
        frame(10'h3f5, 4'h5, 1'b1, 1'b0, 32);
        take("normal 5 bit", {10'h015, 1'b0});
        frame(10'h05a, 4'h8, 1'b0, 1'b1, 16);
        take("stop low", {10'h05a, 1'b1});
        // out of range length is clamped to ten bits
        double_speed_select = 1'b0;
        frame_bits = 4'hf;
        TX.send(10'h1b4, 4'ha, 1'b1, 32, 32);
        take("clamp to 10 bit", {10'h1b4, 1'b0});
    endtask : t_formats
    // low pulse ends just before the first centre sample in both modes
    task automatic t_noise;
        for (int m = 0; m < 2; m++) begin
            double_speed_select = m[0];
            TX.hold(1'b0, m ? 6 : 14);
            TX.hold(1'b1, 400);
            chk("noise start", 11'h000, {10'h000, out_valid});
            frame(10'h1e7, 4'h9, 1'b1, m[0], m ? 16 : 32);
            take("after noise", {10'h1e7, 1'b0});
        end
    endtask : t_noise
    // receiver stalls: two words kept, third dropped
    task automatic t_stall;
        frame(10'h011, 4'h8, 1'b1, 1'b0, 22);
        frame(10'h022, 4'h8, 1'b1, 1'b0, 22);
        frame(10'h033, 4'h8, 1'b1, 1'b0, 32);
        repeat (8) @(posedge sys_clk);
        #1 chk("overrun", 11'h001, {10'h000, seen_ovr});
        take("first kept", {10'h011, 1'b0});
        take("second kept", {10'h022, 1'b0});
        chk("drained", 11'h000, {10'h000, out_valid});
    endtask : t_stall
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        rst = 1'b0;
        double_speed_select = 1'b0;
        frame_bits = 4'h8;
        out_ready = 1'b0;
        err_count = 0;
        n_compared = 0;
        // a clean rising reset edge before the first clock edge resets every flop; sync1, sync2 and prev load high
        #1 rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        chk("reset valid", 11'h000, {10'h000, out_valid});
        t_formats();
        t_noise();
        t_stall();
        end_of_test();
    end
    // watchdog, several times the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        end_of_test();
    end
endmodule : uart_async_rx_recovery_test
